// File: core/ssc_consts.vh
// Constants shared by the synchronous serial clock and buffer controller.
`ifndef SSC_CONSTS_VH
`define SSC_CONSTS_VH
// Register addresses on the plain register port.
`define SSC_ADDR_CTRL1 4'h8
`define SSC_ADDR_CTRL2 4'h9
`define SSC_ADDR_STAT 4'hA
`define SSC_ADDR_BUF_HI 4'h7
// First control register fields.
`define SSC_C1_START 7
`define SSC_C1_ABORT 6
`define SSC_C1_MODE_HI 5
`define SSC_C1_MODE_LO 3
`define SSC_C1_CLK_HI 2
`define SSC_C1_CLK_LO 0
// Second control register fields.
`define SSC_C2_WAIT_HI 4
`define SSC_C2_WAIT_LO 3
`define SSC_C2_CNT_HI 2
`define SSC_C2_CNT_LO 0
// Status bits.
`define SSC_ST_ACTIVE 7
`define SSC_ST_SHIFT 6
// Transfer modes.
`define SSC_MODE_TX8 3'h0
`define SSC_MODE_TX4 3'h2
`define SSC_MODE_TXRX8 3'h4
`define SSC_MODE_RX8 3'h5
`define SSC_MODE_RX4 3'h6
// Clock select codes.
`define SSC_CLK_SLOWEST 3'h0
`define SSC_CLK_RESERVED 3'h6
`define SSC_CLK_EXTERNAL 3'h7
// Period exponents of the internal shift clock (divide by 2^n, each half lasting 2^(n-1) clocks).
`define SSC_DIV_BASE 4'hD
`define SSC_DIV_LOW 4'h5
`define SSC_DIV_FAST_TOP 4'h9
// Bits per word.
`define SSC_BITS8 4'h8
`define SSC_BITS4 4'h4
`endif

// File: core/ssc_buf_mem.v
// Eight-entry data buffer with registered read data.
`timescale 1ns/1ns
module ssc_buf_mem #(
    parameter AW = 3,
    parameter DW = 8
) (
    // Clock.
    input wire clock_i,
    // Write port.
    input wire wr_en_i,
    input wire [AW-1:0] wr_addr_i,
    input wire [DW-1:0] wr_data_i,
    // Read port.
    input wire [AW-1:0] rd_addr_i,
    output reg [DW-1:0] rd_data_o
);
reg [DW-1:0] mem_r [0:(1<<AW)-1];

always @(posedge clock_i) begin
    if (wr_en_i) begin
        mem_r[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem_r[rd_addr_i];
end
endmodule // ssc_buf_mem

// File: core/ssc_ctrl.v
// Clocking, buffer sequencing and status of the synchronous serial port.
`timescale 1ns/1ns
`include "ssc_consts.vh"
// Notes on behaviour
// - Clock code 111 takes the external clock pin; 000..101 use internal, 110 gives no clock.
// - Codes 000..101 give six internal rates; 000 slows with low source.
// - Internal clock is driven on the pin, high when transfer starts.
// - Internal clock halts while software lags on buffer access.
// - Outgoing bits change on the falling clock edge.
// - Incoming bits are sampled on the rising clock edge.
// - First control register is write-only and reads back zero.
// - Wait field stretches internal-clock frame to 1, 2, 4 or 8 word times; external clock ignores it.
// - Word count field picks 1 to 8 words from buffer base upward.
// - 4-bit mode shifts the low nibble; reception zeros the high one.
// - Transmit from lowest entry; receive stores ascending from lowest.
// - Programmed word count is kept after a transfer.
// - Status shows transfer active and shift active flags.
// - With start cleared, active drops at word end or at once on abort.
// - Abort stops the transfer and clears itself.
// - Interrupt fires once the programmed number of words has moved.
module ssc_ctrl #(
    parameter AW = 4
) (
    // Clock and reset.
    input wire clock_i,
    input wire rst_b_i,
    // Register port.
    input wire [AW-1:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    // Clock source.
    input wire low_freq_sel_i,
    input wire low_freq_tick_i,
    // Serial pins.
    input wire sck_i,
    output reg sck_o,
    output reg sck_oe_o,
    input wire sdi_i,
    output reg sdo_o,
    // Event.
    output reg serial_irq_o
);
localparam ST_IDLE = 2'h0;
localparam ST_SHIFT = 2'h1;
localparam ST_WAIT = 2'h2;
localparam ST_HOLD = 2'h3;

reg start_r, abort_r;
reg [2:0] mode_r, clk_sel_r, cnt_r, widx_r;
reg [1:0] wait_r;
reg [1:0] state_r;
reg [7:0] shreg_r;
reg [3:0] bit_r;
reg [13:0] div_r;
reg [7:0] gap_r;
reg sck_in_d_r;
reg buf_touch_r;
reg active_r, shift_r;
reg rd_buf_r;
reg [7:0] rd_word_r;
wire [7:0] mem_q;
reg mem_we;
reg [2:0] mem_wa, mem_ra;
reg [7:0] mem_wd;

wire is_ext = (clk_sel_r == `SSC_CLK_EXTERNAL);
wire is_rsv = (clk_sel_r == `SSC_CLK_RESERVED);
wire nib = (mode_r == `SSC_MODE_TX4) || (mode_r == `SSC_MODE_RX4);
wire do_rx = (mode_r == `SSC_MODE_RX8) || (mode_r == `SSC_MODE_RX4) ||
             (mode_r == `SSC_MODE_TXRX8);
wire do_tx = !((mode_r == `SSC_MODE_RX8) || (mode_r == `SSC_MODE_RX4));
wire [3:0] nbits = nib ? `SSC_BITS4 : `SSC_BITS8;
wire buf_acc = (wr_i || rd_i) && (addr_i <= `SSC_ADDR_BUF_HI);
wire lf_mode = (clk_sel_r == `SSC_CLK_SLOWEST) && low_freq_sel_i;
wire ctrl1_wr = wr_i && (addr_i == `SSC_ADDR_CTRL1);

reg [3:0] half_exp;
always @* begin
    if (clk_sel_r == `SSC_CLK_SLOWEST) begin
        half_exp = low_freq_sel_i ? `SSC_DIV_LOW : `SSC_DIV_BASE;
    end else begin
        half_exp = `SSC_DIV_FAST_TOP - {1'b0, clk_sel_r};
    end
end
wire [13:0] half_mask = (14'h0001 << (half_exp - 4'h1)) - 14'h0001;
wire div_tick = lf_mode ?
    (low_freq_tick_i && ((div_r & half_mask) == half_mask)) :
    ((div_r & half_mask) == half_mask);

// falling and rising edges, internal or external
wire int_fall = !is_ext && !is_rsv && div_tick && sck_o;
wire int_rise = !is_ext && !is_rsv && div_tick && !sck_o;
wire ext_fall = is_ext && sck_in_d_r && !sck_i;
wire ext_rise = is_ext && !sck_in_d_r && sck_i;
wire fall_e = int_fall || ext_fall;
wire rise_e = int_rise || ext_rise;
wire last_bit = (bit_r == nbits - 4'h1);
wire last_word = (widx_r == cnt_r);

ssc_buf_mem #(
    .AW(3),
    .DW(8)
) u_mem (
    .clock_i(clock_i),
    .wr_en_i(mem_we),
    .wr_addr_i(mem_wa),
    .wr_data_i(mem_wd),
    .rd_addr_i(mem_ra),
    .rd_data_o(mem_q)
);

// Software buffer writes and shifter deposits share the one write port.
always @* begin
    mem_we = 1'b0;
    mem_wa = addr_i[2:0];
    mem_wd = wdata_i;
    mem_ra = widx_r;
    if (state_r == ST_SHIFT && rise_e && last_bit && do_rx) begin
        mem_we = 1'b1;
        mem_wa = widx_r;
        mem_wd = nib ? {4'h0, sdi_i, shreg_r[7:5]} : {sdi_i, shreg_r[7:1]};
    end else if (wr_i && buf_acc) begin
        mem_we = 1'b1;
    end
    if (rd_i && buf_acc) begin
        mem_ra = addr_i[2:0];
    end
end

// Buffer data come from the buffer's own read register, so the status
// word is registered here as well and both stand one cycle after the strobe.
always @* begin
    rdata_o = rd_buf_r ? mem_q : rd_word_r;
end

always @(posedge clock_i) begin
    if (!rst_b_i) begin
        start_r <= 1'b0;
        abort_r <= 1'b0;
        mode_r <= 3'h0;
        clk_sel_r <= 3'h0;
        wait_r <= 2'h0;
        cnt_r <= 3'h0;
        state_r <= ST_IDLE;
        widx_r <= 3'h0;
        bit_r <= 4'h0;
        shreg_r <= 8'h00;
        div_r <= 14'h0000;
        gap_r <= 8'h00;
        sck_in_d_r <= 1'b1;
        buf_touch_r <= 1'b0;
        active_r <= 1'b0;
        shift_r <= 1'b0;
        sck_o <= 1'b1;
        sck_oe_o <= 1'b0;
        sdo_o <= 1'b1;
        serial_irq_o <= 1'b0;
        rd_buf_r <= 1'b0;
        rd_word_r <= 8'h00;
    end else begin
        sck_in_d_r <= sck_i;
        serial_irq_o <= 1'b0;
        // The low-frequency source advances the divider only on its ticks.
        if (!lf_mode || low_freq_tick_i) begin
            div_r <= div_r + 14'h0001;
        end
        // pin driven for every clock code but external 111
        sck_oe_o <= !is_ext;
        if (buf_acc) begin
            buf_touch_r <= 1'b1;
        end
        if (ctrl1_wr) begin
            start_r <= wdata_i[`SSC_C1_START];
            abort_r <= wdata_i[`SSC_C1_ABORT];
            mode_r <= wdata_i[`SSC_C1_MODE_HI:`SSC_C1_MODE_LO];
            clk_sel_r <= wdata_i[`SSC_C1_CLK_HI:`SSC_C1_CLK_LO];
        end
        if (wr_i && addr_i == `SSC_ADDR_CTRL2) begin
            wait_r <= wdata_i[`SSC_C2_WAIT_HI:`SSC_C2_WAIT_LO];
            cnt_r <= wdata_i[`SSC_C2_CNT_HI:`SSC_C2_CNT_LO];
        end
        rd_buf_r <= rd_i && buf_acc;
        rd_word_r <= 8'h00;
        if (rd_i && addr_i == `SSC_ADDR_STAT) begin
            rd_word_r <= {active_r, shift_r, 6'h00};
        end
        // abort stops and self-clears, flag drops at once
        if (abort_r) begin
            // A new abort written in this very cycle must not be lost.
            abort_r <= ctrl1_wr && wdata_i[`SSC_C1_ABORT];
            state_r <= ST_IDLE;
            active_r <= 1'b0;
            shift_r <= 1'b0;
            sck_o <= 1'b1;
        end else begin
            case (state_r)
            ST_IDLE: begin
                sck_o <= 1'b1;
                if (start_r && !is_rsv) begin
                    // pin high at start, lowest entry first
                    state_r <= ST_SHIFT;
                    widx_r <= 3'h0;
                    bit_r <= 4'h0;
                    active_r <= 1'b1;
                    shift_r <= 1'b1;
                    buf_touch_r <= buf_acc;
                    div_r <= 14'h0000;
                end
            end
            ST_SHIFT: begin
                if (int_fall || int_rise) begin
                    sck_o <= !sck_o;
                end
                // One register shifts right on rising edges: sent bits
                // leave at the bottom while received bits enter the top.
                if (fall_e && bit_r == 4'h0) begin
                    shreg_r <= mem_q;
                end
                // drive next bit on falling edge
                if (fall_e && do_tx) begin
                    sdo_o <= (bit_r == 4'h0) ? mem_q[0] : shreg_r[0];
                end
                if (rise_e) begin
                    shreg_r <= {sdi_i, shreg_r[7:1]};
                    bit_r <= bit_r + 4'h1;
                    if (last_bit) begin
                        bit_r <= 4'h0;
                        shift_r <= 1'b0;
                        gap_r <= 8'h00;
                        state_r <= ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                // internal-clock frame is word time shifted by the wait field, external skips the gap
                if (int_fall || int_rise) begin
                    gap_r <= gap_r + 8'h01;
                end
                if (is_ext || gap_r >= ({4'h0, nbits} <<
                        ({1'b0, wait_r} + 3'h1)) - {3'h0, nbits, 1'b0}) begin
                    state_r <= ST_HOLD;
                    if (last_word) begin
                        serial_irq_o <= 1'b1;
                    end
                end
            end
            ST_HOLD: begin
                if (!start_r) begin
                    // ends after the word in flight
                    state_r <= ST_IDLE;
                    active_r <= 1'b0;
                end else if (!last_word) begin
                    widx_r <= widx_r + 3'h1;
                    state_r <= ST_SHIFT;
                    shift_r <= 1'b1;
                end else if (is_ext || buf_touch_r) begin
                    // internal clock waits for a buffer access
                    widx_r <= 3'h0;
                    buf_touch_r <= buf_acc;
                    state_r <= ST_SHIFT;
                    shift_r <= 1'b1;
                end
            end
            default: begin
                state_r <= ST_IDLE;
            end
            endcase
        end
    end
end
endmodule // ssc_ctrl

// File: tb/ssc_ctrl_properties.sv
// Port checker for the serial clock and buffer controller.
`timescale 1ns/1ns
module ssc_ctrl_properties #(
    parameter AW = 4
) (
    // Watched ports.
    input wire clock_i,
    input wire rst_b_i,
    input wire [AW-1:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] rdata_o,
    input wire sck_o,
    input wire sck_oe_o,
    input wire sdo_o,
    input wire serial_irq_o
);
    reg [2:0] ccode_r = 3'h0;
    wire c1_wr = wr_i && addr_i == 4'h8;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    always @(posedge clock_i) begin
        if (c1_wr) begin
            ccode_r <= wdata_i[2:0];
        end
    end
    a_ctrl_read_zero:
    assert property ($past(rd_i) && $past(addr_i) > 4'h7 &&
        $past(addr_i) != 4'hA |-> rdata_o == 8'h00)
        else $error("control or unmapped read not zero");
    a_ext_no_drive:
    assert property (c1_wr && wdata_i[2:0] == 3'h7 |-> ##[1:3] !sck_oe_o)
        else $error("clock pin driven in external mode");
    a_int_drives:
    assert property (c1_wr && wdata_i[2:0] != 3'h7 |-> ##[1:3] sck_oe_o)
        else $error("clock pin not driven in internal mode");
    a_start_high:
    assert property (c1_wr && wdata_i[7] && wdata_i[2:0] < 3'h6 && sck_o
        |=> sck_o [*4]) else $error("clock not high at transfer start");
    a_rsvd_quiet:
    assert property (c1_wr && wdata_i[2:0] == 3'h6 && sck_o |=> sck_o [*8])
        else $error("clock toggles with reserved code");
    a_sdo_lead:
    assert property ($rose(sck_o) |-> $stable(sdo_o))
        else $error("data out moved on trailing edge");
    a_half_hi:
    assert property (ccode_r == 3'h5 && sck_oe_o && $rose(sck_o)
        |-> sck_o [*8]) else $error("high half period too short");
    a_half_lo:
    assert property (ccode_r == 3'h5 && $fell(sck_o) |-> !sck_o [*8] ##1 sck_o)
        else $error("low half period wrong");
    a_irq_pulse:
    assert property (serial_irq_o |=> !serial_irq_o)
        else $error("interrupt longer than one cycle");
    cover property (serial_irq_o);
    cover property (!sck_oe_o);
    cover property (c1_wr && wdata_i[2:0] == 3'h6);
endmodule // ssc_ctrl_properties

bind ssc_ctrl ssc_ctrl_properties #(.AW(AW)) u_chk (.clock_i(clock_i),
    .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
    .sdo_o(sdo_o), .serial_irq_o(serial_irq_o));

// File: tb/ssc_peer.sv
// Behavioural far-side peripheral on the serial pins.
`timescale 1ns/1ns
module ssc_peer (
    // Pins and control.
    input wire sck_i,
    input wire sdo_i,
    input wire clr_i,
    input wire [3:0] nbits_i,
    output reg sdi_o
);
    reg [7:0] tx_w [0:7];
    reg [7:0] rx_w [0:7];
    integer w = 0;
    integer b = 0;
    initial sdi_o = 1'b1;
    always @(posedge clr_i) begin
        w = 0;
        b = 0;
    end
    always @(negedge sck_i) begin
        if (!clr_i && w < 8) begin
            sdi_o <= tx_w[w][b];
        end
    end
    always @(posedge sck_i) begin
        if (!clr_i && w < 8) begin
            rx_w[w][b] = sdo_i;
            b = b + 1;
            if (b == nbits_i) begin
                b = 0;
                w = w + 1;
            end
        end
    end
endmodule // ssc_peer

// File: tb/ssc_ctrl_test.sv
// Self-checking bench for the serial clock and buffer controller.
`timescale 1ns/1ns
`include "ssc_consts.vh"
module ssc_ctrl_test;
    reg clock_i = 1'b0;
    reg rst_b_i = 1'b0;
    reg [3:0] addr_i = 4'h0;
    reg [7:0] wdata_i = 8'h00;
    reg wr_i = 1'b0;
    reg rd_i = 1'b0;
    reg tick = 1'b0;
    reg lf_sel = 1'b0;
    reg [1:0] tdiv = 2'h0;
    reg sck_ext = 1'b1;
    reg clr = 1'b1;
    reg [3:0] nbits = 4'h8;
    reg [7:0] n_irq = 8'h00;
    reg [7:0] t;
    reg [31:0] seed = 32'h0000AB1E;
    reg [2:0] mode;
    reg [2:0] clk;
    reg [3:0] n;
    reg [7:0] txb [0:7];
    integer n_mismatch = 0;
    integer tests_run = 0;
    integer i;
    integer k;
    integer r;
    wire [7:0] rdata_o;
    wire sck_o, sck_oe_o, sdo_o, sdi, irq;
    wire sck_pin = sck_oe_o ? sck_o : sck_ext;
    always #4 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        n_irq <= n_irq + {7'h00, irq};
        // The low-frequency source ticks every fourth clock.
        tdiv <= tdiv + 2'h1;
        tick <= (tdiv == 2'h3);
    end
    ssc_ctrl #(.AW(4)) DUT (.clock_i(clock_i), .rst_b_i(rst_b_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .low_freq_sel_i(lf_sel), .low_freq_tick_i(tick),
        .sck_i(sck_pin), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .sdi_i(sdi),
        .sdo_o(sdo_o), .serial_irq_o(irq));
    ssc_peer peer (.sck_i(sck_pin), .sdo_i(sdo_o), .clr_i(clr),
        .nbits_i(nbits), .sdi_o(sdi));
    function [31:0] rnd(input integer unused);
        begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            rnd = seed;
        end
    endfunction
    function [7:0] wmask(input [2:0] m);
        wmask = (m == `SSC_MODE_RX4 || m == `SSC_MODE_TX4) ? 8'h0F : 8'hFF;
    endfunction
    function [7:0] exp_rx(input [7:0] b, input [2:0] m);
        exp_rx = b & wmask(m);
    endfunction
    task conclude;
        begin
            if (n_mismatch == 0 && tests_run > 0) begin
                $display("*** PASS ***");
            end else begin
                $display("*** FAIL ***");
            end
            $finish;
        end
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("BAD %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // Strobes are left up so back-to-back accesses assign them once.
    task wr(input [3:0] a, input [7:0] d);
        begin
            addr_i <= a;
            wdata_i <= d;
            wr_i <= 1'b1;
            rd_i <= 1'b0;
            @(posedge clock_i);
        end
    endtask
    task idle(input integer c);
        begin
            wr_i <= 1'b0;
            rd_i <= 1'b0;
            repeat (c) @(posedge clock_i);
        end
    endtask
    task rd(input [3:0] a, input [7:0] m, input [7:0] e);
        begin
            addr_i <= a;
            rd_i <= 1'b1;
            wr_i <= 1'b0;
            @(posedge clock_i);
            rd_i <= 1'b0;
            // Read data are looked at mid-cycle, while they stand.
            @(negedge clock_i);
            chk(rdata_o & m, e);
            @(posedge clock_i);
        end
    endtask
    initial begin
        repeat (6) @(posedge clock_i);
        rst_b_i <= 1'b1;
        @(posedge clock_i);
        rd(4'h8, 8'hFF, 8'h00);
        rd(4'h9, 8'hFF, 8'h00);
        rd(4'hB, 8'hFF, 8'h00);
        rd(4'hA, 8'hC0, 8'h00);
        for (i = 0; i < 6; i = i + 1) begin
            mode = (i < 2) ? `SSC_MODE_TXRX8 : (i == 2) ? `SSC_MODE_RX4 :
                (i == 3) ? `SSC_MODE_TX8 : (i == 4) ? `SSC_MODE_TX4 :
                `SSC_MODE_RX8;
            clk = (i == 3 || i == 5) ? 3'h7 : (i == 4) ? 3'h0 : 3'h5;
            n = (i > 2) ? 4'h1 : 4'h3;
            nbits <= (wmask(mode) == 8'h0F) ? 4'h4 : 4'h8;
            lf_sel <= (i == 4);
            wr(4'h8, {2'b01, mode, clk});
            if (i == 0 || i == 2 || i == 3) begin
                wr(4'h9, {3'h0, (i == 0) ? 2'b01 : 2'b00,
                    n[2:0] - 3'h1});
            end
            for (k = 0; k < 8; k = k + 1) begin
                r = rnd(0);
                peer.tx_w[k] = r[7:0];
                r = rnd(0);
                txb[k] = r[7:0];
                wr(k[3:0], txb[k]);
            end
            clr <= 1'b0;
            t = n_irq;
            wr(4'h8, {2'b10, mode, clk});
            idle(1);
            rd(4'hA, 8'h80, 8'h80);
            if (clk == 3'h7) begin
                repeat (8) begin
                    sck_ext <= 1'b0;
                    idle(8);
                    sck_ext <= 1'b1;
                    idle(8);
                end
            end
            k = 0;
            while (n_irq == t && k < 3000) begin
                idle(1);
                k = k + 1;
            end
            if (k == 3000) begin
                n_mismatch = n_mismatch + 1;
                conclude;
            end
            idle(40);
            chk(n_irq - t, 8'h01);
            chk({7'h00, sck_o}, 8'h01);
            // The second round ends by clearing start alone, the rest abort.
            wr(4'h8, {1'b0, i != 1, mode, clk});
            idle(2);
            rd(4'hA, 8'h80, 8'h00);
            for (k = 0; k < n; k = k + 1) begin
                if (mode != `SSC_MODE_TX8 && mode != `SSC_MODE_TX4) begin
                    rd(k[3:0], 8'hFF, exp_rx(peer.tx_w[k], mode));
                end
                if (mode != `SSC_MODE_RX4 && mode != `SSC_MODE_RX8) begin
                    chk(peer.rx_w[k] & wmask(mode),
                        txb[k] & wmask(mode));
                end
            end
            clr <= 1'b1;
        end
        wr(4'h8, {2'b01, `SSC_MODE_TX8, 3'h6});
        wr(4'h8, {2'b10, `SSC_MODE_TX8, 3'h6});
        idle(40);
        rd(4'hA, 8'h40, 8'h00);
        wr(4'h8, {2'b01, `SSC_MODE_TX8, 3'h6});
        idle(4);
        conclude;
    end
endmodule // ssc_ctrl_test
